// *** logic/spsel_top.sv ***
// Purpose: Routes radio status, a divided clock or a constant to 3 pins.
// Assumes: Status inputs are on CLK; CHIP_SELECT_N comes from a pin.
// Notes:   Config and status registers sit on a classic Wishbone slave.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - Three pins, each with 6-bit source code
// - Pin B is serial out while selected
// - Pin B undriven after reset
// - Pin A drives crystal/192 after reset
// - Sleep forces low codes to invert level; pin B to its complement
// - Forced level holds until core ready
// - Codes 0x20 and up run in sleep
// - Code 0x2E leaves pin undriven, except pin B while selected
// - Code 0x00 tracks receive threshold
// - Code 0x01 threshold or end, until empty
// - Codes 0x02/0x03 follow transmit fill level
// - Overflow/underflow flags held until flush
// - Code 0x06 from sync until packet end
// - Code 0x07 good packet until first read
// - Code 0x09 clear channel; test codes idle
// - Code 0x0A synthesizer lock for interrupts
// - Code 0x0B serial clock, invertible
// - Codes 0x0C/0x0D synchronous and asynchronous data
// - Code 0x0E carrier sense, cleared in idle
// - Code 0x0F checksum match, cleared on receive
// - Code 0x1B amplifier power-down signal
// - Code 0x2F constant low, invert gives high
module spsel_top
   import spsel_pkg::*;
(
   input  wire logic                 CLK,
   input  wire logic                 SRST,
   input  wire logic                 WB_CYC_I,
   input  wire logic                 WB_STB_I,
   input  wire logic                 WB_WE_I,
   input  wire logic [spsel_pkg::ADR_W-1:0] WB_ADR_I,
   input  wire logic [3:0]           WB_SEL_I,
   input  wire logic [31:0]          WB_DAT_I,
   output logic      [31:0]          WB_DAT_O,
   output logic                      WB_ACK_O,
   input  wire logic                 CHIP_SELECT_N,
   input  wire logic                 SPI_SO_DATA,
   input  wire logic                 SPI_SO_EN,
   input  wire logic                 RX_AT_THR,
   input  wire logic                 RX_EMPTY,
   input  wire logic                 PKT_END,
   input  wire logic                 TX_AT_THR,
   input  wire logic                 TX_FULL,
   input  wire logic                 RX_OVERFLOW,
   input  wire logic                 TX_UNDERFLOW,
   input  wire logic                 RX_FLUSH,
   input  wire logic                 TX_FLUSH,
   input  wire logic                 SYNC_SEEN,
   input  wire logic                 PKT_DISCARD,
   input  wire logic                 PKT_CRC_GOOD,
   input  wire logic                 RX_FIRST_READ,
   input  wire logic                 CLEAR_CHANNEL,
   input  wire logic                 PLL_LOCK,
   input  wire logic                 SERIAL_CLK,
   input  wire logic                 SYNC_RX_DATA,
   input  wire logic                 ASYNC_RX_DATA,
   input  wire logic                 RSSI_ABOVE,
   input  wire logic                 RADIO_IDLE,
   input  wire logic                 CRC_CHECK_DONE,
   input  wire logic                 CRC_CHECK_PASS,
   input  wire logic                 RX_ENTER,
   input  wire logic                 AMP_POWERDOWN,
   input  wire logic                 SLEEP,
   input  wire logic                 CORE_READY_N,
   output logic                      STATUS_OUT_A,
   output logic                      STATUS_OE_A,
   output logic                      STATUS_OUT_B,
   output logic                      STATUS_OE_B,
   output logic                      STATUS_OUT_C,
   output logic                      STATUS_OE_C
);
   import spsel_pkg::*;

   logic [CFG_W-1:0] cfg_q [NPINS];
   logic [NPINS-1:0] lvl_q;
   logic [NPINS-1:0] oe_q;
   logic [NPINS-1:0] lvl_d;
   logic [NPINS-1:0] oe_d;
   logic [NSRC-1:0]  src;
   logic             cs_meta_q;
   logic             cs_q;
   logic [1:0]       so_meta_q;
   logic [1:0]       so_q;
   logic             div192;
   logic             sleep_hold_q;
   logic             forced;
   logic             rx_eop_q;
   logic             tx_full_q;
   logic             rx_ovf_q;
   logic             tx_unf_q;
   logic             sync_q;
   logic             crc_pkt_q;
   logic             crc_match_q;
   logic             carrier;
   logic             wb_req;
   logic [31:0]      rd_d;

   // Picks the level a code names, before sleep handling and inversion
   function automatic logic pick_src(input logic [5:0] code,
                                     input logic [NSRC-1:0] s,
                                     input logic dv);
      logic r;
      r = 1'b0;
      if (code < SEL_SLEEP_RUN)
      begin
         r = s[code[4:0]];
      end
      else if (code == SEL_DIV192)
      begin
         r = dv;
      end
      return r;
   endfunction

   // Pin B's reset word leaves it undriven
   function automatic logic [CFG_W-1:0] cfg_reset(input int idx);
      logic [CFG_W-1:0] r;
      r = RST_CFG_C;
      if (idx == PIN_A)
      begin
         r = RST_CFG_A;
      end
      else if (idx == PIN_B)
      begin
         r = RST_CFG_B;
      end
      return r;
   endfunction

   // Chip select comes from a pin, serial-out from the serial clock side
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         cs_meta_q <= 1'b1;
         cs_q      <= 1'b1;
         so_meta_q <= '0;
         so_q      <= '0;
      end
      else
      begin
         cs_meta_q <= CHIP_SELECT_N;
         cs_q      <= cs_meta_q;
         so_meta_q <= {SPI_SO_EN, SPI_SO_DATA};
         so_q      <= so_meta_q;
      end
   end

   spsel_clkdiv u_div
   (
      .CLK     (CLK),
      .SRST    (SRST),
      .div_out (div192)
   );

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         sleep_hold_q <= 1'b0;
      end
      else if (SLEEP)
      begin
         sleep_hold_q <= 1'b1;
      end
      else if (!CORE_READY_N)
      begin
         sleep_hold_q <= 1'b0;
      end
   end

   // Forcing starts in the sleep cycle itself, not one later
   assign forced = SLEEP | sleep_hold_q;

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         rx_eop_q <= 1'b0;
      end
      else if (RX_AT_THR || PKT_END)
      begin
         rx_eop_q <= 1'b1;
      end
      else if (RX_EMPTY)
      begin
         rx_eop_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         tx_full_q <= 1'b0;
      end
      else if (TX_FULL)
      begin
         tx_full_q <= 1'b1;
      end
      else if (!TX_AT_THR)
      begin
         tx_full_q <= 1'b0;
      end
   end

   // sticky overflow and underflow; the event beats a flush
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         rx_ovf_q <= 1'b0;
      end
      else if (RX_OVERFLOW)
      begin
         rx_ovf_q <= 1'b1;
      end
      else if (RX_FLUSH)
      begin
         rx_ovf_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         tx_unf_q <= 1'b0;
      end
      else if (TX_UNDERFLOW)
      begin
         tx_unf_q <= 1'b1;
      end
      else if (TX_FLUSH)
      begin
         tx_unf_q <= 1'b0;
      end
   end

   // sync to packet end or abort
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         sync_q <= 1'b0;
      end
      else if (SYNC_SEEN)
      begin
         sync_q <= 1'b1;
      end
      else if (PKT_END || PKT_DISCARD || RX_OVERFLOW || TX_UNDERFLOW)
      begin
         sync_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         crc_pkt_q <= 1'b0;
      end
      else if (PKT_CRC_GOOD)
      begin
         crc_pkt_q <= 1'b1;
      end
      else if (RX_FIRST_READ)
      begin
         crc_pkt_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         crc_match_q <= 1'b0;
      end
      else if (CRC_CHECK_DONE && CRC_CHECK_PASS)
      begin
         crc_match_q <= 1'b1;
      end
      else if (CRC_CHECK_DONE || RX_ENTER)
      begin
         crc_match_q <= 1'b0;
      end
   end

   assign carrier = RSSI_ABOVE & ~RADIO_IDLE;

   // Test and unlisted codes below 0x20 read as zero
   always_comb
   begin
      src = '0;
      src[SEL_RX_THR[4:0]]   = RX_AT_THR;
      src[SEL_RX_EOP[4:0]]   = rx_eop_q;
      src[SEL_TX_THR[4:0]]   = TX_AT_THR;
      src[SEL_TX_FULL[4:0]]  = tx_full_q;
      src[SEL_RX_OVF[4:0]]   = rx_ovf_q;
      src[SEL_TX_UNF[4:0]]   = tx_unf_q;
      src[SEL_SYNC[4:0]]     = sync_q;
      src[SEL_CRC_PKT[4:0]]  = crc_pkt_q;
      src[SEL_CCA[4:0]]      = CLEAR_CHANNEL;
      src[SEL_LOCK[4:0]]     = PLL_LOCK;
      src[SEL_SER_CLK[4:0]]  = SERIAL_CLK;
      src[SEL_SYNC_DAT[4:0]] = SYNC_RX_DATA;
      src[SEL_ASYN_DAT[4:0]] = ASYNC_RX_DATA;
      src[SEL_CARRIER[4:0]]  = carrier;
      src[SEL_CRC_OK[4:0]]   = crc_match_q;
      src[SEL_AMP_PD[4:0]]   = AMP_POWERDOWN;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++)
      begin : g_pin
         logic [5:0] code;
         logic       inv;

         assign code = cfg_q[gi][SEL_MSB:0];
         assign inv  = cfg_q[gi][INV_BIT];

         always_comb
         begin
            lvl_d[gi] = 1'b0;
            oe_d[gi]  = 1'b1;
            if (code == SEL_HIZ)
            begin
               oe_d[gi] = 1'b0;
            end
            else if (forced && code < SEL_SLEEP_RUN)
            begin
               lvl_d[gi] = (gi == PIN_B) ? ~inv : inv;
            end
            else
            begin
               lvl_d[gi] = pick_src(code, src, div192) ^ inv;
            end
            if (gi == PIN_B && !cs_q)
            begin
               lvl_d[gi] = so_q[0];
               oe_d[gi]  = so_q[1];
            end
         end

         always_ff @(posedge CLK)
         begin
            if (SRST)
            begin
               lvl_q[gi] <= 1'b0;
               oe_q[gi]  <= (gi != PIN_B);
            end
            else
            begin
               lvl_q[gi] <= lvl_d[gi];
               oe_q[gi]  <= oe_d[gi];
            end
         end
      end
   endgenerate

   assign STATUS_OUT_A = lvl_q[PIN_A];
   assign STATUS_OE_A  = oe_q[PIN_A];
   assign STATUS_OUT_B = lvl_q[PIN_B];
   assign STATUS_OE_B  = oe_q[PIN_B];
   assign STATUS_OUT_C = lvl_q[PIN_C];
   assign STATUS_OE_C  = oe_q[PIN_C];

   // One-cycle ack; the gap after each ack keeps transfers single
   assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         WB_ACK_O <= 1'b0;
      end
      else
      begin
         WB_ACK_O <= wb_req;
      end
   end

   generate
      for (gi = 0; gi < NPINS; gi++)
      begin : g_cfg
         localparam logic [7:0] OFS = (gi == PIN_A) ? OFS_CFG_A :
                                      (gi == PIN_B) ? OFS_CFG_B : OFS_CFG_C;

         always_ff @(posedge CLK)
         begin
            if (SRST)
            begin
               cfg_q[gi] <= cfg_reset(gi);
            end
            else if (wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == OFS)
            begin
               cfg_q[gi] <= WB_DAT_I[CFG_W-1:0];
            end
         end
      end
   endgenerate

   always_comb
   begin
      rd_d = '0;
      case (WB_ADR_I)
         OFS_CFG_A:
         begin
            rd_d[CFG_W-1:0] = cfg_q[PIN_A];
         end
         OFS_CFG_B:
         begin
            rd_d[CFG_W-1:0] = cfg_q[PIN_B];
         end
         OFS_CFG_C:
         begin
            rd_d[CFG_W-1:0] = cfg_q[PIN_C];
         end
         OFS_STATUS:
         begin
            rd_d[0]   = sleep_hold_q;
            rd_d[3:1] = lvl_q;
            rd_d[6:4] = oe_q;
            rd_d[7]   = cs_q;
         end
         default:
         begin
            rd_d = '0;
         end
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         WB_DAT_O <= '0;
      end
      else if (wb_req && !WB_WE_I)
      begin
         WB_DAT_O <= rd_d;
      end
   end
endmodule // spsel_top
`default_nettype wire

// *** logic/spsel_pkg.sv ***
// Purpose: Constants shared by the status output pin selector.
// Assumes: One crystal clock domain, 32-bit classic Wishbone registers.
// Notes:   Selection codes are 6 bits; bit 6 of each config word inverts.
`default_nettype none
package spsel_pkg;
   localparam int          NPINS        = 3;
   localparam int          PIN_A        = 0;
   localparam int          PIN_B        = 1;
   localparam int          PIN_C        = 2;
   localparam int          CFG_W        = 7;
   localparam int          SEL_MSB      = 5;
   localparam int          INV_BIT      = 6;
   localparam int          ADR_W        = 8;
   localparam int          NSRC         = 32;

   // Register byte offsets
   localparam logic [7:0]  OFS_CFG_A    = 8'h00;
   localparam logic [7:0]  OFS_CFG_B    = 8'h04;
   localparam logic [7:0]  OFS_CFG_C    = 8'h08;
   localparam logic [7:0]  OFS_STATUS   = 8'h0C;

   // Selection codes
   localparam logic [5:0]  SEL_RX_THR   = 6'h00;
   localparam logic [5:0]  SEL_RX_EOP   = 6'h01;
   localparam logic [5:0]  SEL_TX_THR   = 6'h02;
   localparam logic [5:0]  SEL_TX_FULL  = 6'h03;
   localparam logic [5:0]  SEL_RX_OVF   = 6'h04;
   localparam logic [5:0]  SEL_TX_UNF   = 6'h05;
   localparam logic [5:0]  SEL_SYNC     = 6'h06;
   localparam logic [5:0]  SEL_CRC_PKT  = 6'h07;
   localparam logic [5:0]  SEL_CCA      = 6'h09;
   localparam logic [5:0]  SEL_LOCK     = 6'h0A;
   localparam logic [5:0]  SEL_SER_CLK  = 6'h0B;
   localparam logic [5:0]  SEL_SYNC_DAT = 6'h0C;
   localparam logic [5:0]  SEL_ASYN_DAT = 6'h0D;
   localparam logic [5:0]  SEL_CARRIER  = 6'h0E;
   localparam logic [5:0]  SEL_CRC_OK   = 6'h0F;
   localparam logic [5:0]  SEL_AMP_PD   = 6'h1B;
   localparam logic [5:0]  SEL_SLEEP_RUN = 6'h20;
   localparam logic [5:0]  SEL_HIZ      = 6'h2E;
   localparam logic [5:0]  SEL_CONST0   = 6'h2F;
   localparam logic [5:0]  SEL_DIV192   = 6'h3F;

   // Reset contents of the three config words
   localparam logic [6:0]  RST_CFG_A    = {1'b0, SEL_DIV192};
   localparam logic [6:0]  RST_CFG_B    = {1'b0, SEL_HIZ};
   localparam logic [6:0]  RST_CFG_C    = {1'b0, SEL_CONST0};

   // Crystal clock divider
   localparam int          XO_DIV       = 192;
   localparam int          XO_HALF      = XO_DIV / 2;
   localparam int          DIV_W        = 7;
endpackage
`default_nettype wire

// *** logic/spsel_clkdiv.sv ***
// Purpose: Divides the crystal clock down to a square wave level.
// Assumes: Output is sampled as data, never used as a clock inside.
// Notes:   Even divide only; half period is a package constant.
`timescale 1ns/100ps
`default_nettype none
module spsel_clkdiv
(
   input  wire logic CLK,
   input  wire logic SRST,
   output logic      div_out
);
   import spsel_pkg::*;

   localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(XO_HALF - 1);

   logic [DIV_W-1:0] cnt_q;

   always_ff @(posedge CLK)
   begin
      if (SRST || cnt_q == HALF_LAST)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_q + DIV_W'(1);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         div_out <= 1'b0;
      end
      else if (cnt_q == HALF_LAST)
      begin
         div_out <= ~div_out;
      end
   end
endmodule // spsel_clkdiv
`default_nettype wire

// *** dv/spsel_props.sv ***
// Purpose: Port-level checks for the status pin selector.
// Assumes: Config words change only through acked Wishbone writes.
// Notes:   Shadows the config words from bus traffic to judge the pins.
`timescale 1ns/100ps
`default_nettype none
module spsel_props
   import spsel_pkg::*;
(
   input wire logic             CLK,
   input wire logic             SRST,
   input wire logic             WB_CYC_I,
   input wire logic             WB_STB_I,
   input wire logic             WB_WE_I,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic [3:0]       WB_SEL_I,
   input wire logic [31:0]      WB_DAT_I,
   input wire logic             WB_ACK_O,
   input wire logic             SLEEP,
   input wire logic             CORE_READY_N,
   input wire logic             PLL_LOCK,
   input wire logic             RX_OVERFLOW,
   input wire logic             STATUS_OUT_A,
   input wire logic             STATUS_OE_A,
   input wire logic             STATUS_OE_B,
   input wire logic             STATUS_OUT_C,
   input wire logic             STATUS_OE_C
);
   logic [6:0] cfg_q [NPINS];
   logic       wr;
   assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
   // Updated one edge after the design's copy, the same edge the pins follow it
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         cfg_q[0] <= RST_CFG_A;
         cfg_q[1] <= RST_CFG_B;
         cfg_q[2] <= RST_CFG_C;
      end
      else
         for (int i = 0; i < NPINS; i++)
            if (wr && WB_ADR_I == 8'(4 * i))
               cfg_q[i] <= WB_DAT_I[6:0];
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("bus request not acked in one cycle");
   chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   chk_reset_pins: assert property ($fell(SRST) |-> STATUS_OE_A && !STATUS_OE_B && STATUS_OE_C)
      else $error("pin enables wrong after reset");
   chk_hiz_code: assert property (cfg_q[2][5:0] == SEL_HIZ |-> !STATUS_OE_C)
      else $error("pin driven with high impedance code");
   // The shadow word matches the pins in the same cycle, so it is read at the consequent
   chk_const_level: assert property (
      cfg_q[2][5:0] == SEL_CONST0 |-> STATUS_OE_C && STATUS_OUT_C == cfg_q[2][6])
      else $error("constant code level wrong");
   chk_sleep_force: assert property (
      SLEEP ##1 cfg_q[0][5:0] < SEL_SLEEP_RUN |-> STATUS_OE_A && STATUS_OUT_A == cfg_q[0][6])
      else $error("pin a not forced in sleep");
   chk_wake_hold: assert property (
      $fell(SLEEP) && CORE_READY_N ##2 cfg_q[0][5:0] < SEL_SLEEP_RUN
      |-> STATUS_OUT_A == cfg_q[0][6])
      else $error("pin a released before core ready");
   chk_lock_pass: assert property (
      !SLEEP && !CORE_READY_N ##1 !SLEEP ##1 cfg_q[2][5:0] == SEL_LOCK
      |-> STATUS_OUT_C == ($past(PLL_LOCK) ^ cfg_q[2][6]))
      else $error("lock level not passed to pin c");
   chk_ovf_flag: assert property (
      !SLEEP && !CORE_READY_N && RX_OVERFLOW ##1 !SLEEP ##1 cfg_q[2][5:0] == SEL_RX_OVF
      |-> STATUS_OUT_C == !cfg_q[2][6])
      else $error("overflow not shown on pin c");
endmodule // spsel_props
bind spsel_top spsel_props u_spsel_props (.CLK(CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
   .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .SLEEP(SLEEP), .CORE_READY_N(CORE_READY_N),
   .PLL_LOCK(PLL_LOCK), .RX_OVERFLOW(RX_OVERFLOW), .STATUS_OUT_A(STATUS_OUT_A),
   .STATUS_OE_A(STATUS_OE_A), .STATUS_OE_B(STATUS_OE_B), .STATUS_OUT_C(STATUS_OUT_C),
   .STATUS_OE_C(STATUS_OE_C));
`default_nettype wire

// *** dv/spsel_host_model.sv ***
// Purpose: Host controller side that samples the three status pins.
// Assumes: No pull resistors on the pins.
// Notes:   An undriven pin shows a changing level, never a stale one.
`timescale 1ns/100ps
`default_nettype none
module spsel_host_model
(
   input  wire logic       clk,
   input  wire logic       chip_select_n,
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   output logic      [2:0] pin_level,
   output logic            b_seen
);
   logic [2:0] last_q = 3'h0;
   always_comb
      for (int i = 0; i < 3; i++)
         pin_level[i] = pin_oe[i] ? pin_out[i] : !last_q[i];
   always_ff @(posedge clk)
      last_q <= pin_level;
   // status on the shared pin only trusted with chip select high
   always_ff @(posedge clk)
      if (chip_select_n)
         b_seen <= pin_level[1];
endmodule // spsel_host_model
`default_nettype wire

// *** dv/spsel_top_tb_top.sv ***
// Purpose: Self-checking bench for the status pin selector.
// Assumes: Inputs change by non-blocking assignment after a rising edge.
// Notes:   Pin levels are judged through the host model.
`timescale 1ns/100ps
`default_nettype none
module spsel_top_tb_top;
   import spsel_pkg::*;
   logic        clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ack, chip_select_n = 1, b_seen;
   logic        so_dat = 0, so_en = 0, idle = 0, sleep = 0, crn = 0;
   logic [7:0]  adr = 0;
   logic [3:0]  sel = 0;
   logic [31:0] wdat = 0, rdat, q;
   logic [8:0]  lv = 0;
   logic [13:0] ev = 0;
   logic [2:0]  out, oe, lvl;
   int          err_count = 0, samples_checked = 0;
   spsel_top u_spsel_top (.CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .CHIP_SELECT_N(chip_select_n), .SPI_SO_DATA(so_dat), .SPI_SO_EN(so_en), .RX_AT_THR(lv[0]),
      .TX_AT_THR(lv[1]), .CLEAR_CHANNEL(lv[2]), .PLL_LOCK(lv[3]), .SERIAL_CLK(lv[4]),
      .SYNC_RX_DATA(lv[5]), .ASYNC_RX_DATA(lv[6]), .AMP_POWERDOWN(lv[7]), .RSSI_ABOVE(lv[8]),
      .PKT_END(ev[0]), .RX_OVERFLOW(ev[1]), .TX_UNDERFLOW(ev[2]), .RX_FLUSH(ev[3]),
      .TX_FLUSH(ev[4]), .SYNC_SEEN(ev[5]), .PKT_DISCARD(ev[6]), .PKT_CRC_GOOD(ev[7]),
      .RX_FIRST_READ(ev[8]), .CRC_CHECK_DONE(ev[9]), .CRC_CHECK_PASS(ev[10]),
      .RX_ENTER(ev[11]), .RX_EMPTY(ev[12]), .TX_FULL(ev[13]), .RADIO_IDLE(idle),
      .SLEEP(sleep), .CORE_READY_N(crn), .STATUS_OUT_A(out[0]), .STATUS_OE_A(oe[0]),
      .STATUS_OUT_B(out[1]), .STATUS_OE_B(oe[1]), .STATUS_OUT_C(out[2]), .STATUS_OE_C(oe[2]));
   spsel_host_model u_spsel_host_model (.clk(clk), .chip_select_n(chip_select_n), .pin_out(out), .pin_oe(oe),
      .pin_level(lvl), .b_seen(b_seen));
   initial
      forever #2.5 clk = ~clk;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits on ack with no assumed latency; the bound only catches a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      r = rdat;
      if (n >= 50)
         err_count++;
      cyc <= 0;
      stb <= 0;
      we <= 0;
      @(posedge clk);
   endtask
   task automatic t_reset();
      check("enables", oe, 3'b101);
      wb(0, OFS_CFG_A, 32'h0, q);
      check("cfg a", q, 32'(RST_CFG_A));
      wb(0, OFS_CFG_B, 32'h0, q);
      check("cfg b", q, 32'(RST_CFG_B));
      wb(1, 8'h40, 32'h0000_007F, q);
      wb(0, 8'h40, 32'h0, q);
      check("unmapped", q, 32'h0);
      wb(0, OFS_CFG_A, 32'h0, q);
      check("cfg a kept", q, 32'(RST_CFG_A));
      $display("test reset done");
   endtask
   // Measures the divided clock on pin a, where the reset word puts it
   task automatic t_div();
      int n;
      logic l;
      for (int k = 0; k < 2; k++)
      begin
         n = 0;
         l = lvl[0];
         while (lvl[0] === l && n < 300)
         begin
            tick(1);
            n++;
         end
      end
      check("half period", n, XO_HALF);
      $display("test divider done");
   endtask
   task automatic t_levels();
      logic [5:0] c [9] = '{SEL_RX_THR, SEL_TX_THR, SEL_CCA, SEL_LOCK, SEL_SER_CLK,
                            SEL_SYNC_DAT, SEL_ASYN_DAT, SEL_AMP_PD, SEL_CARRIER};
      logic [5:0] d [4] = '{6'h08, 6'h10, 6'h1A, SEL_CONST0};
      for (int i = 0; i < 18; i++)
      begin
         wb(1, OFS_CFG_C, {25'h0, i[0], c[i/2]}, q);
         lv <= 9'h0;
         tick(3);
         check("level off", lvl[2], i[0]);
         lv <= 9'(1 << (i / 2));
         tick(2);
         check("level on", lvl[2], !i[0]);
      end
      idle <= 1;
      tick(2);
      check("carrier idle", lvl[2], 1'b1);
      idle <= 0;
      for (int i = 0; i < 8; i++)
      begin
         wb(1, OFS_CFG_C, {25'h0, i[0], d[i/2]}, q);
         lv <= 9'h1FF;
         tick(3);
         check("quiet code", lvl[2], i[0]);
      end
      wb(1, OFS_CFG_C, {25'h0, 1'b1, SEL_HIZ}, q);
      check("hiz c", oe[2], 1'b0);
      $display("test levels done");
   endtask
   task automatic t_events();
      logic [5:0]  c [10] = '{SEL_RX_OVF, SEL_TX_UNF, SEL_SYNC, SEL_SYNC, SEL_SYNC, SEL_SYNC,
                              SEL_CRC_PKT, SEL_RX_EOP, SEL_CRC_OK, SEL_CRC_OK};
      logic [13:0] s [10] = '{14'h2, 14'h4, 14'h20, 14'h20, 14'h20, 14'h20, 14'h80, 14'h1,
                              14'h600, 14'h600};
      logic [13:0] x [10] = '{14'h8, 14'h10, 14'h1, 14'h40, 14'h2, 14'h4, 14'h100, 14'h1000,
                              14'h800, 14'h200};
      lv <= 9'h0;
      for (int i = 0; i < 10; i++)
      begin
         wb(1, OFS_CFG_C, {25'h0, i[0], c[i]}, q);
         ev <= x[i];
         tick(1);
         ev <= 14'h0;
         tick(3);
         check("flag idle", lvl[2], i[0]);
         ev <= s[i];
         tick(1);
         ev <= 14'h0;
         tick(5);
         check("flag held", lvl[2], !i[0]);
         ev <= x[i];
         tick(1);
         ev <= 14'h0;
         tick(3);
         check("flag cleared", lvl[2], i[0]);
      end
      // Full is held while the fill stays at threshold, then drops below it
      wb(1, OFS_CFG_C, {25'h0, 1'b0, SEL_TX_FULL}, q);
      lv <= 9'h002;
      ev <= 14'h2000;
      tick(1);
      ev <= 14'h0;
      tick(4);
      check("full held", lvl[2], 1'b1);
      lv <= 9'h0;
      tick(3);
      check("full drained", lvl[2], 1'b0);
      $display("test events done");
   endtask
   task automatic t_sleep();
      wb(1, OFS_CFG_A, {25'h0, 1'b0, SEL_LOCK}, q);
      wb(1, OFS_CFG_B, {25'h0, 1'b0, SEL_ASYN_DAT}, q);
      wb(1, OFS_CFG_C, {25'h0, 1'b1, SEL_CONST0}, q);
      lv <= 9'h008;
      tick(3);
      check("awake", lvl, 3'b101);
      sleep <= 1;
      crn <= 1;
      tick(2);
      check("asleep", lvl, 3'b110);
      sleep <= 0;
      tick(4);
      check("wake hold", lvl, 3'b110);
      wb(0, OFS_STATUS, 32'h0, q);
      check("hold bit", q[0], 1'b1);
      crn <= 0;
      tick(3);
      check("ready", lvl, 3'b101);
      $display("test sleep done");
   endtask
   task automatic t_cs();
      wb(1, OFS_CFG_B, {25'h0, 1'b1, SEL_CONST0}, q);
      chip_select_n <= 0;
      so_en <= 1;
      tick(6);
      check("serial low", {oe[1], lvl[1]}, 2'b10);
      so_dat <= 1;
      tick(6);
      check("serial high", {oe[1], lvl[1]}, 2'b11);
      so_en <= 0;
      tick(6);
      check("serial off", oe[1], 1'b0);
      chip_select_n <= 1;
      tick(6);
      check("status back", {b_seen, lvl[1]}, 2'b11);
      wb(1, OFS_CFG_B, {25'h0, 1'b1, SEL_HIZ}, q);
      sleep <= 1;
      tick(2);
      check("hiz sleep", oe[1], 1'b0);
      sleep <= 0;
      $display("test chip select done");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      finish_test();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      t_reset();
      t_div();
      t_levels();
      t_events();
      t_sleep();
      t_cs();
      finish_test();
   end
endmodule // spsel_top_tb_top
`default_nettype wire
